// >>> core/cic_pkg.sv
// Constants and types shared by the counter input conditioning block
package cic_pkg;

    // Clock rate of the fabric clock in kHz
    localparam int CIC_CLK_KHZ = 100000;
    // Filter sample tick is 40 MHz, derived as a fraction of the fabric clock
    localparam int CIC_FILT_KHZ = 40000;
    // Consecutive filter samples needed per setting
    localparam int CIC_N_SHORT = 5;
    localparam int CIC_N_MID = 257;
    localparam int CIC_N_LONG = 101800;
    // Filter settings
    localparam logic [1:0] CIC_FILT_OFF = 2'h0;
    localparam logic [1:0] CIC_FILT_125NS = 2'h1;
    localparam logic [1:0] CIC_FILT_6US = 2'h2;
    localparam logic [1:0] CIC_FILT_2MS = 2'h3;
    // Filter settings reset value (disabled)
    localparam logic [1:0] CIC_FILT_RST = 2'h0;
    // Prescaler settings
    localparam logic [1:0] CIC_PRE_OFF = 2'h0;
    localparam logic [1:0] CIC_PRE_DIV2 = 2'h1;
    localparam logic [1:0] CIC_PRE_DIV8 = 2'h2;
    // Counter source selects
    localparam logic [2:0] CIC_SRC_EXT = 3'h0;
    localparam logic [2:0] CIC_SRC_FAST = 3'h1;
    localparam logic [2:0] CIC_SRC_MED = 3'h2;
    localparam logic [2:0] CIC_SRC_SLOW = 3'h3;
    localparam logic [2:0] CIC_SRC_BP10 = 3'h4;
    // Register map over the plain port
    localparam logic [3:0] CIC_A_FILT = 4'h0;
    localparam logic [3:0] CIC_A_CTL0 = 4'h1;
    localparam logic [3:0] CIC_A_CTL1 = 4'h2;
    localparam logic [3:0] CIC_A_CNT0 = 4'h3;
    localparam logic [3:0] CIC_A_CNT1 = 4'h4;
    localparam logic [3:0] CIC_A_BUF0 = 4'h5;
    localparam logic [3:0] CIC_A_BUF1 = 4'h6;
    localparam logic [3:0] CIC_A_STAT = 4'h7;
    // Control register fields
    localparam int CIC_F_SRC = 0;
    localparam int CIC_F_PRE = 3;
    localparam int CIC_F_DUP = 5;
    localparam int CIC_F_POS = 6;
    localparam int CIC_F_DOWN = 7;
    localparam int CIC_F_CASC = 8;
    localparam int CIC_F_EN = 9;
    localparam logic [31:0] CIC_CTL_RST = 32'h0000_0000;
    localparam logic [31:0] CIC_ZERO = 32'h0000_0000;

    // Synchronisation modes, one-hot
    typedef enum logic [2:0] {
        CIC_SYNC_FAST = 3'b001,
        CIC_SYNC_INT = 3'b010,
        CIC_SYNC_EXT = 3'b100
    } cic_sync_t;

endpackage : cic_pkg

// >>> core/cic_core.sv
// Counter input conditioning: filters, prescalers, sync modes, two counters
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module cic_core
    import cic_pkg::*;
#(
    parameter int N_LONG = CIC_N_LONG
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [7:0] pin_in,
    input wire logic fast_internal_timebase,
    input wire logic medium_internal_timebase,
    input wire logic slow_internal_timebase,
    input wire logic backplane_ten_mhz_clock,
    input wire logic [1:0] fwd_en,
    output logic [1:0] fwd_out,
    output logic [1:0] terminal_count,
    output logic [1:0] ctr_out
);
    // Input lines: 0..3 terminal, 4..5 trigger bus, 6 star, 7 spare
    localparam int NIN = 8;

    // Two-stage synchroniser, first stage read only by the second
    logic [NIN-1:0] pin_s1_reg;
    logic [NIN-1:0] pin_s2_reg;
    logic [3:0] tb_s1_reg;
    logic [3:0] tb_s2_reg;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            tb_s1_reg <= '0;
            tb_s2_reg <= '0;
        end else if (ce) begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
            tb_s1_reg <= {backplane_ten_mhz_clock, slow_internal_timebase,
                          medium_internal_timebase, fast_internal_timebase};
            tb_s2_reg <= tb_s1_reg;
        end
    end

    // Filter tick at 40 MHz from 100 MHz by phase accumulation
    // No whole divider gives 40 MHz, so the tick spacing jitters by a clock
    logic [16:0] ph_reg;
    logic tick;
    assign tick = (ph_reg + 17'(CIC_FILT_KHZ)) >= 17'(CIC_CLK_KHZ);
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ph_reg <= '0;
        end else if (ce) begin
            if (tick) begin
                ph_reg <= 17'(ph_reg + 17'(CIC_FILT_KHZ) - 17'(CIC_CLK_KHZ));
            end else begin
                ph_reg <= 17'(ph_reg + 17'(CIC_FILT_KHZ));
            end
        end
    end

    // Samples required for a filter setting
    function automatic logic [16:0] need(input logic [1:0] s);
        case (s)
            CIC_FILT_125NS: need = 17'(CIC_N_SHORT);
            CIC_FILT_6US: need = 17'(CIC_N_MID);
            default: need = 17'(N_LONG);
        endcase
    endfunction : need

    // Per-input settings, two bits each
    logic [15:0] filt_reg;
    logic [NIN-1:0] flt_reg;
    logic [16:0] fcnt_reg [NIN];
    always_ff @(posedge clk) begin
        if (!rstn) begin
            filt_reg <= {8{CIC_FILT_RST}};
        end else if (ce && wr && addr == CIC_A_FILT) begin
            filt_reg <= wdata[15:0];
        end
    end

    // Debounce filters, one counter per input
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flt_reg <= '0;
            for (int i = 0; i < NIN; i++) begin
                fcnt_reg[i] <= '0;
            end
        end else if (ce) begin
            for (int i = 0; i < NIN; i++) begin
                if (filt_reg[2*i +: 2] == CIC_FILT_OFF) begin
                    // Bypass: follow the synchronised pin
                    flt_reg[i] <= pin_s2_reg[i];
                    fcnt_reg[i] <= '0;
                end else if (tick) begin
                    // Count holds the new-level samples seen so far
                    // old level restarts count
                    if (pin_s2_reg[i] == flt_reg[i]) begin
                        fcnt_reg[i] <= '0;
                    end else if (17'(fcnt_reg[i] + 17'h0_0001)
                                 >= need(filt_reg[2*i +: 2])) begin
                        flt_reg[i] <= pin_s2_reg[i];
                        fcnt_reg[i] <= '0;
                    end else begin
                        fcnt_reg[i] <= 17'(fcnt_reg[i] + 17'h0_0001);
                    end
                end
            end
        end
    end

    // Forwarded triggers skip the filter so they keep their own edges
    // forwarding uses the unfiltered pins
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fwd_out <= '0;
        end else if (ce) begin
            fwd_out[0] <= fwd_en[0] & pin_s2_reg[0];
            fwd_out[1] <= fwd_en[1] & pin_s2_reg[4];
        end
    end

    // Control per counter; gate/source line picks come from control bits
    logic [31:0] ctl_reg [2];
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctl_reg[0] <= CIC_CTL_RST;
            ctl_reg[1] <= CIC_CTL_RST;
        end else if (ce && wr) begin
            if (addr == CIC_A_CTL0) begin
                ctl_reg[0] <= wdata;
            end
            if (addr == CIC_A_CTL1) begin
                ctl_reg[1] <= wdata;
            end
        end
    end

    function automatic cic_sync_t pick(input logic [31:0] c);
        logic [2:0] s;
        s = c[CIC_F_SRC +: 3];
        if (c[CIC_F_DUP] || c[CIC_F_POS] || s == CIC_SRC_FAST) begin
            pick = CIC_SYNC_FAST;
        end else if (s == CIC_SRC_MED || s == CIC_SRC_SLOW ||
                     s == CIC_SRC_BP10) begin
            pick = CIC_SYNC_INT;
        end else begin
            pick = CIC_SYNC_EXT;
        end
    endfunction : pick

    // Counters, their delayed-source and edge state
    logic [31:0] cnt_reg [2];
    logic [31:0] base_reg [2];
    logic [31:0] buf_reg [2];
    logic [1:0] src_d_reg;
    logic [1:0] src_dd_reg;
    // Source delayed one more clock; external mode samples the gate on it
    logic [1:0] src_ddd_reg;
    logic [1:0] gate_sy_reg;
    logic [1:0] gate_d_reg;
    logic [2:0] pre_reg [2];
    logic [1:0] stored_reg;
    logic [1:0] src_raw;
    logic [1:0] gate_raw;
    cic_sync_t mode [2];

    // Source and gate selection per counter
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            mode[k] = pick(ctl_reg[k]);
            case (ctl_reg[k][CIC_F_SRC +: 3])
                CIC_SRC_FAST: src_raw[k] = tb_s2_reg[0];
                CIC_SRC_MED: src_raw[k] = tb_s2_reg[1];
                CIC_SRC_SLOW: src_raw[k] = tb_s2_reg[2];
                CIC_SRC_BP10: src_raw[k] = tb_s2_reg[3];
                default: src_raw[k] = flt_reg[k];
            endcase
            gate_raw[k] = ctl_reg[k][CIC_F_CASC] ?
                (terminal_count[1-k] | ctr_out[1-k]) : flt_reg[k+2];
        end
    end

    // Counting engine
    always_ff @(posedge clk) begin
        if (!rstn) begin
            src_d_reg <= '0;
            src_dd_reg <= '0;
            src_ddd_reg <= '0;
            gate_sy_reg <= '0;
            gate_d_reg <= '0;
            stored_reg <= '0;
            terminal_count <= '0;
            ctr_out <= '0;
            for (int k = 0; k < 2; k++) begin
                cnt_reg[k] <= CIC_ZERO;
                base_reg[k] <= CIC_ZERO;
                buf_reg[k] <= CIC_ZERO;
                pre_reg[k] <= '0;
            end
        end else if (ce) begin
            src_d_reg <= src_raw;
            src_dd_reg <= src_d_reg;
            src_ddd_reg <= src_dd_reg;
            for (int k = 0; k < 2; k++) begin
                logic rise;
                logic fall;
                logic drise;
                logic pre_ok;
                logic cnt_ev;
                rise = src_d_reg[k] & ~src_dd_reg[k];
                fall = ~src_d_reg[k] & src_dd_reg[k];
                drise = src_dd_reg[k] & ~src_ddd_reg[k];
                pre_ok = 1'b1;
                cnt_ev = 1'b0;
                stored_reg[k] <= 1'b0;
                terminal_count[k] <= 1'b0;
                // under prevention gate synced every cycle
                // fast mode syncs on source rise
                // internal mode syncs on source fall
                // external mode syncs on delayed rise
                if (ctl_reg[k][CIC_F_DUP] ||
                    (mode[k] == CIC_SYNC_FAST && rise) ||
                    (mode[k] == CIC_SYNC_INT && fall) ||
                    (mode[k] == CIC_SYNC_EXT && drise)) begin
                    gate_sy_reg[k] <= gate_raw[k];
                end
                // one count step per source rising edge, or per two or eight edges with the external-mode prescaler
                if (ctl_reg[k][CIC_F_EN] && rise) begin
                    if (mode[k] == CIC_SYNC_EXT &&
                        ctl_reg[k][CIC_F_PRE +: 2] != CIC_PRE_OFF) begin
                        pre_reg[k] <= 3'(pre_reg[k] + 3'h1);
                        if (ctl_reg[k][CIC_F_PRE +: 2] == CIC_PRE_DIV2) begin
                            pre_ok = pre_reg[k][0];
                        end else begin
                            pre_ok = (pre_reg[k] == 3'h7);
                        end
                    end
                    cnt_ev = pre_ok;
                end
                // updates one clock after the clock that samples the source into src_d_reg
                if (cnt_ev) begin
                    if (ctl_reg[k][CIC_F_DOWN]) begin
                        cnt_reg[k] <= 32'(cnt_reg[k] - 32'h0000_0001);
                        terminal_count[k] <= (cnt_reg[k] == 32'h0000_0001);
                    end else begin
                        cnt_reg[k] <= 32'(cnt_reg[k] + 32'h0000_0001);
                        terminal_count[k] <= (cnt_reg[k] == 32'hFFFF_FFFE);
                    end
                    if ((ctl_reg[k][CIC_F_DOWN] && cnt_reg[k] == 32'h0000_0001)
                        || (!ctl_reg[k][CIC_F_DOWN] &&
                            cnt_reg[k] == 32'hFFFF_FFFE)) begin
                        ctr_out[k] <= ~ctr_out[k];
                    end
                end
                gate_d_reg[k] <= gate_sy_reg[k];
                // store count since previous gate rise
                if (gate_sy_reg[k] && !gate_d_reg[k]) begin
                    buf_reg[k] <= 32'(cnt_reg[k] - base_reg[k]);
                    base_reg[k] <= cnt_reg[k];
                    stored_reg[k] <= 1'b1;
                end
            end
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata <= CIC_ZERO;
        end else if (ce) begin
            if (rd) begin
                case (addr)
                    CIC_A_FILT: rdata <= {16'h0000, filt_reg};
                    CIC_A_CTL0: rdata <= ctl_reg[0];
                    CIC_A_CTL1: rdata <= ctl_reg[1];
                    CIC_A_CNT0: rdata <= cnt_reg[0];
                    CIC_A_CNT1: rdata <= cnt_reg[1];
                    CIC_A_BUF0: rdata <= buf_reg[0];
                    CIC_A_BUF1: rdata <= buf_reg[1];
                    CIC_A_STAT: rdata <= {24'h00_0000, flt_reg};
                    default: rdata <= CIC_ZERO;
                endcase
            end else begin
                rdata <= CIC_ZERO;
            end
        end
    end

    // Buffer stores only on a gate rise
    a_store_gate: assert property (@(posedge clk) disable iff (!rstn)
        ce && gate_sy_reg[0] && !gate_d_reg[0] |=> stored_reg[0])
        else $error("gate rise did not store");
    a_store_cause: assert property (@(posedge clk) disable iff (!rstn)
        stored_reg[0] && $past(ce)
        |-> $past(gate_sy_reg[0]) && !$past(gate_d_reg[0]))
        else $error("store without gate rise");
    a_filt_off: assert property (@(posedge clk) disable iff (!rstn)
        ce && filt_reg[1:0] == CIC_FILT_OFF
        |=> flt_reg[0] == $past(pin_s2_reg[0]))
        else $error("disabled filter not transparent");
    a_filt_hold: assert property (@(posedge clk) disable iff (!rstn)
        filt_reg[1:0] != CIC_FILT_OFF && fcnt_reg[0] == '0 && $stable(filt_reg)
        |=> $stable(flt_reg[0]))
        else $error("filter passed level too early");
    a_fwd_raw: assert property (@(posedge clk) disable iff (!rstn)
        ce |=> fwd_out[0] == ($past(fwd_en[0]) & $past(pin_s2_reg[0])))
        else $error("forward not unfiltered");
    a_cnt_step: assert property (@(posedge clk) disable iff (!rstn)
        ce && !src_d_reg[0] && !src_dd_reg[0] && $stable(ctl_reg[0])
        |=> $stable(cnt_reg[0]))
        else $error("count moved without source edge");
    a_tick_gap: assert property (@(posedge clk) disable iff (!rstn)
        ce && tick |=> !tick)
        else $error("filter tick too fast");
    a_pre_ext: assert property (@(posedge clk) disable iff (!rstn)
        mode[0] != CIC_SYNC_EXT |=> $stable(pre_reg[0]))
        else $error("prescaler ran on internal source");
    // Counter 1 shares this logic, so most checks watch counter 0
    a_tc_once: assert property (@(posedge clk) disable iff (!rstn)
        ce && terminal_count[0] |=> !terminal_count[0])
        else $error("terminal count longer than one cycle");
    a_out_toggle: assert property (@(posedge clk) disable iff (!rstn)
        $rose(terminal_count[0]) |-> $changed(ctr_out[0]))
        else $error("output did not toggle on terminal count");
    a_ext_sync: assert property (@(posedge clk) disable iff (!rstn)
        ce && mode[0] == CIC_SYNC_EXT && !(src_dd_reg[0] && !src_ddd_reg[0])
        |=> $stable(gate_sy_reg[0]))
        else $error("external gate sync off the delayed rise");
    a_int_sync: assert property (@(posedge clk) disable iff (!rstn)
        ce && mode[1] == CIC_SYNC_INT && !(!src_d_reg[1] && src_dd_reg[1])
        |=> $stable(gate_sy_reg[1]))
        else $error("internal gate sync off the falling edge");
endmodule : cic_core
`default_nettype wire

// >>> test/cic_pins.sv
// Partner model: external source, gate, trigger and timebase drivers
`timescale 1ns/10ps
`default_nettype none
module cic_pins (
    output logic [11:0] lines,
    input wire logic clk
);
    // Index 7:0 pins, 8 fast, 9 medium, 10 slow, 11 backplane clock
    initial begin
        lines = 12'h000;
    end
    // Change one line right after a rising edge, as a real driver would
    task automatic set_line(input int idx, input logic val);
        @(posedge clk);
        lines[idx] <= val;
    endtask : set_line
    // source at 20 MHz or below
    // Low phase of three clocks keeps every period at five clocks or more
    task automatic pulse(input int idx, input int n, input int hi);
        for (int i = 0; i < n; i++) begin
            set_line(idx, 1'b1);
            repeat (hi - 1) @(posedge clk);
            set_line(idx, 1'b0);
            repeat (2) @(posedge clk);
        end
    endtask : pulse
endmodule : cic_pins
`default_nettype wire

// >>> test/cic_core_tb.sv
// Self-checking bench for the counter input conditioning block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
    fail_count++; $display("FAIL %s exp %h got %h", nm, ex, got); end end
module cic_core_tb;
    import cic_pkg::*;
    // One expected read result, noted by the driver
    typedef struct {string n; logic [31:0] v;} cic_note_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_q = 1'b0;
    logic [31:0] rdata;
    logic [1:0] fwd_en = 2'b00;
    logic [1:0] fwd_out;
    logic [1:0] tc;
    logic [1:0] cout;
    logic [11:0] lines;
    logic [31:0] seed = 32'h0000_9262;
    logic [31:0] en_b = 32'h0000_0001 << CIC_F_EN;
    cic_note_t notes[$];
    cic_note_t cur;
    int fail_count = 0;
    int num_checks = 0;
    int tc0_seen = 0;
    int cnt0 = 0;
    // Prescaler table: setting, source pulses, expected count step
    logic [1:0] pre_t[3] = '{CIC_PRE_DIV8, CIC_PRE_DIV2, CIC_PRE_OFF};
    int n_t[3] = '{16, 10, 7};
    int d_t[3] = '{2, 5, 7};

    // Clock of 100 MHz
    always #5 clk = ~clk;

    // Short long-filter count keeps the run brief
    cic_core #(.N_LONG(20)) dut_u (
        .clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pin_in(lines[7:0]),
        .fast_internal_timebase(lines[8]),
        .medium_internal_timebase(lines[9]),
        .slow_internal_timebase(lines[10]),
        .backplane_ten_mhz_clock(lines[11]),
        .fwd_en(fwd_en), .fwd_out(fwd_out),
        .terminal_count(tc), .ctr_out(cout)
    );
    cic_pins pins_u (.lines(lines), .clk(clk));

    // Watcher: compares read data in the cycle after each read strobe
    always @(posedge clk) begin
        rd_q <= rd;
        if (tc[0] === 1'b1) begin
            tc0_seen++;
        end
        if (rd_q) begin
            cur = notes.pop_front();
            `CHK(cur.n, cur.v, rdata)
        end
    end

    // Xorshift source of random pulse widths, two to four clocks
    function automatic int hi_w();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return 2 + int'(seed % 3);
    endfunction : hi_w

    // Control word for a counter: source, prescaler, enable
    function automatic logic [31:0] mk(logic [2:0] s, logic [1:0] p);
        return en_b | 32'(s) | (32'(p) << CIC_F_PRE);
    endfunction : mk

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    // Read strobe for one cycle; the expected value waits in the queue
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e,
                          input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        notes.push_back('{nm, e});
        @(posedge clk);
        rd <= 1'b0;
    endtask : reg_rd

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    // Watchdog far beyond the several hundred clocks the tests need
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        reg_rd(CIC_A_FILT, CIC_ZERO, "filt rst");
        reg_rd(CIC_A_CTL0, CIC_CTL_RST, "ctl0 rst");
        reg_rd(CIC_A_CNT0, CIC_ZERO, "cnt0 rst");
        // Unmapped places read zero, so no hidden prescaler state leaks
        for (int a = 8; a < 16; a++) begin
            reg_rd(4'(a), CIC_ZERO, "unmapped");
        end
        // Pins 0 and 6 on the short filter, pin 5 left unfiltered
        reg_wr(CIC_A_FILT, 32'h0000_1001);
        fwd_en <= 2'b01;
        pins_u.set_line(5, 1'b1);
        pins_u.set_line(0, 1'b1);
        repeat (5) @(posedge clk);
        `CHK("fwd0", 1'b1, fwd_out[0])
        reg_rd(CIC_A_STAT, 32'h0000_0020, "short pulse");
        pins_u.set_line(0, 1'b0);
        // A low sample in mid-qualification restarts the count
        pins_u.set_line(6, 1'b1);
        repeat (8) @(posedge clk);
        pins_u.set_line(6, 1'b0);
        repeat (2) @(posedge clk);
        pins_u.set_line(6, 1'b1);
        repeat (8) @(posedge clk);
        reg_rd(CIC_A_STAT, 32'h0000_0020, "restart");
        repeat (12) @(posedge clk);
        reg_rd(CIC_A_STAT, 32'h0000_0060, "passed");
        reg_wr(CIC_A_FILT, CIC_ZERO);
        // Trigger-bus forwarding on the second line
        pins_u.set_line(4, 1'b1);
        fwd_en <= 2'b11;
        repeat (4) @(posedge clk);
        `CHK("fwd1", 1'b1, fwd_out[1])
        // Every prescaler setting on the external source
        for (int i = 0; i < 3; i++) begin
            reg_wr(CIC_A_CTL0, mk(CIC_SRC_EXT, pre_t[i]));
            pins_u.pulse(0, n_t[i], hi_w());
            cnt0 += d_t[i];
            repeat (6) @(posedge clk);
            reg_rd(CIC_A_CNT0, 32'(cnt0), "prescale");
        end
        // Divide by eight is ignored on an internal timebase
        reg_wr(CIC_A_CTL1, mk(CIC_SRC_SLOW, CIC_PRE_DIV8));
        pins_u.pulse(10, 8, hi_w());
        repeat (6) @(posedge clk);
        reg_rd(CIC_A_CNT1, 32'h0000_0008, "cnt1 slow");
        // Buffered counts with duplicate prevention on
        reg_wr(CIC_A_CTL0, mk(CIC_SRC_EXT, CIC_PRE_OFF) | 32'h0000_0020);
        pins_u.pulse(2, 1, 4);
        pins_u.pulse(0, 3, hi_w());
        cnt0 += 3;
        pins_u.pulse(2, 1, 4);
        repeat (6) @(posedge clk);
        reg_rd(CIC_A_BUF0, 32'h0000_0003, "buf delta");
        pins_u.pulse(2, 1, 4);
        repeat (6) @(posedge clk);
        reg_rd(CIC_A_BUF0, CIC_ZERO, "buf no src");
        // Without prevention a gate rise waits for a source edge
        reg_wr(CIC_A_CTL0, mk(CIC_SRC_EXT, CIC_PRE_OFF));
        pins_u.pulse(0, 2, hi_w());
        cnt0 += 2;
        pins_u.pulse(2, 1, 4);
        repeat (6) @(posedge clk);
        reg_rd(CIC_A_BUF0, CIC_ZERO, "buf held");
        // Clock enable low freezes all state, source pulses included
        ce <= 1'b0;
        pins_u.pulse(0, 2, hi_w());
        ce <= 1'b1;
        repeat (6) @(posedge clk);
        reg_rd(CIC_A_CNT0, 32'(cnt0), "frozen");
        // Counter 1 buffers its count when counter 0 ends its count
        reg_wr(CIC_A_CTL1, mk(CIC_SRC_SLOW, CIC_PRE_OFF) | 32'h0000_0120);
        // Count down to zero: one terminal count, output toggles
        reg_wr(CIC_A_CTL0, mk(CIC_SRC_EXT, CIC_PRE_OFF) | 32'h0000_0080);
        pins_u.pulse(0, cnt0, hi_w());
        repeat (6) @(posedge clk);
        reg_rd(CIC_A_CNT0, CIC_ZERO, "cnt0 down");
        reg_rd(CIC_A_BUF1, 32'h0000_0008, "cascade");
        repeat (3) @(posedge clk);
        `CHK("tc0 pulses", 1, tc0_seen)
        `CHK("out0", 1'b1, cout[0])
        `CHK("out1", 1'b0, cout[1])
        `CHK("tc1", 1'b0, tc[1])
        give_verdict();
    end
endmodule : cic_core_tb
`default_nettype wire
